// [rtl/rcd_pkg.sv]
package rcd_pkg;

    // Field widths of the command and address path
    localparam int ADDR_W  = 16;
    localparam int BANK_W  = 3;
    localparam int CKE_W   = 2;
    localparam int ODT_W   = 2;
    localparam int RANK_W  = 4;
    localparam int CLK_W   = 4;

    // Extra cycles a command is held in three-cycle timing
    localparam logic [1:0] HOLD_3T_CYCLES = 2'h2;
    localparam logic [1:0] HOLD_NONE      = 2'h0;

    // Reset values
    localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
    localparam logic [BANK_W-1:0] BANK_RST = 3'h0;
    localparam logic              STRB_RST = 1'h1;
    localparam logic [RANK_W-1:0] RANK_IDLE_N = 4'hf;
    localparam logic [1:0]        TWO_RANK_UNUSED_N = 2'h3;

    // Rank-independent part of a command, also the parity set
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [BANK_W-1:0] bank;
        logic              row_strobe_n;
        logic              col_strobe_n;
        logic              write_en_n;
    } cmd_t;

    localparam cmd_t CMD_RST = '{addr: ADDR_RST, bank: BANK_RST,
                                 row_strobe_n: STRB_RST, col_strobe_n: STRB_RST,
                                 write_en_n: STRB_RST};

    // Rank-dependent controls, outside the parity set
    typedef struct packed {
        logic [CKE_W-1:0] clk_enable;
        logic [ODT_W-1:0] term_enable;
    } ctl_t;

    // Static configuration from the internal control settings
    typedef struct packed {
        logic             disable_copy_b;
        logic [CLK_W-1:0] disable_clk;
        logic             three_cycle;
        logic             invert_copy_b;
    } cfg_t;

endpackage

// [rtl/rcd_register.sv]
// How it works
// - 22 rank-independent bits plus 4 control bits go out on copies A and B, rank selects per mode.
// - With the quad-select strap high, two rank selects come in and each goes out twice.
// - With the strap low, four rank selects come in and each goes out once.
// - All inputs are captured on the rising edge of the core clock.
// - Command and address outputs update only when exactly one rank select is low.
// - Parity is even over address, bank, row, column, write strobe and the parity bit.
// - A parity mismatch on a cycle with exactly one rank select low pulls the open-drain error output low.
// - Clock enable, termination enable and rank selects stay out of the parity.
// - Reset ignores inputs but the strap and analog supply, clears registers and disables all outputs but error and clock enable.
// - The clock is fanned out to four output pairs and one feedback pair.
// - A grounded analog supply is reported on PLL_BYPASSED as the clock-multiplier bypass test mode; no multiplier is modelled.
// - Control settings disable unused outputs.
// - One- or three-cycle command timing and copy-B inversion are supported.
`timescale 1ns/1ps
`default_nettype none

module rcd_register
    import rcd_pkg::*;
(
    input  wire logic              CORE_CLK,
    input  wire logic              NRST,
    input  wire cmd_t              CMD_IN,
    input  wire logic              PARITY_IN,
    input  wire ctl_t              CTL_IN,
    input  wire logic [RANK_W-1:0] RANK_SELECT_IN_N,
    input  wire logic              QUAD_SELECT_STRAP_N,
    input  wire logic              PLL_ANALOG_SUPPLY,
    input  wire cfg_t              CFG,
    output var  cmd_t              CMD_OUT_A,
    output var  cmd_t              CMD_OUT_B,
    output var  ctl_t              CTL_OUT_A,
    output var  ctl_t              CTL_OUT_B,
    output var  logic [RANK_W-1:0] RANK_SELECT_OUT_N,
    output var  logic              OUTPUTS_ENABLED,
    output var  logic              COPY_B_ENABLED,
    output var  logic              PARITY_ERROR_OUT_N_O,
    output var  logic              PARITY_ERROR_OUT_N_OE,
    output var  logic [CLK_W-1:0]  CLK_FANOUT,
    output var  logic [CLK_W-1:0]  CLK_FANOUT_N,
    output var  logic              FEEDBACK_CLK_OUT,
    output var  logic              FEEDBACK_CLK_OUT_N,
    output var  logic              PLL_BYPASSED,
    output var  logic              FOUR_RANK_SELECT_MODE
);

    typedef struct packed {
        // Command and control copies
        cmd_t              cmd_a;
        cmd_t              cmd_b;
        ctl_t              ctl_a;
        ctl_t              ctl_b;
        logic [RANK_W-1:0] rank_out_n;
        logic              out_en;
        logic              copy_b_en;
        // Parity pipeline and open-drain error pin
        cmd_t              par_cmd;
        logic              par_bit;
        logic              par_valid;
        logic              err_oe;
        logic              err_o;
        // Mode, clock outputs and three-cycle hold
        logic              four_mode;
        logic              clk_phase;
        logic [CLK_W-1:0]  clk_mask;
        logic [CLK_W-1:0]  fan_p;
        logic [CLK_W-1:0]  fan_n;
        logic              fb_n;
        logic [1:0]        hold_cnt;
        logic              bypass;
    } state_t;

    // Full state in one register, next value built below
    state_t state_q;
    state_t state_d;

    // Rank selects seen in this mode; unused upper inputs read as idle
    logic [RANK_W-1:0] rank_eff_n;
    logic              one_rank;
    logic              take_cmd;

    // Counts the low selects; unused upper ones arrive already forced idle
    function automatic logic exactly_one_low(input logic [RANK_W-1:0] v_n);
        logic [2:0] cnt;
        cnt = 3'h0;
        for (int i = 0; i < RANK_W; i++) begin
            cnt = cnt + {2'h0, ~v_n[i]};
        end
        return cnt == 3'h1;
    endfunction

    // Select decode feeding both the command path and the parity check
    always_comb begin
        rank_eff_n = state_q.four_mode ? RANK_SELECT_IN_N
                                       : {TWO_RANK_UNUSED_N, RANK_SELECT_IN_N[1:0]};
        one_rank = exactly_one_low(rank_eff_n);
        // In three-cycle timing a command is held, so a new one is dropped
        take_cmd = one_rank && (state_q.hold_cnt == HOLD_NONE);
    end

    // Next state of the whole block; reset is folded in here, so the
    // register below needs no reset branch of its own
    always_comb begin
        state_d = state_q;
        if (!NRST) begin
            // Inputs ignored, outputs parked, mode strap and analog supply caught while held
            state_d.cmd_a      = CMD_RST;
            state_d.cmd_b      = CMD_RST;
            state_d.ctl_a      = '0;
            state_d.ctl_b      = '0;

            // Selects idle and command drivers off
            state_d.rank_out_n = RANK_IDLE_N;
            state_d.out_en     = 1'b0;
            state_d.copy_b_en  = 1'b0;

            // Parity pipeline emptied so no stale error follows release
            state_d.par_cmd    = CMD_RST;
            state_d.par_bit    = 1'b0;
            state_d.par_valid  = 1'b0;
            state_d.err_oe     = 1'b0;
            state_d.err_o      = 1'b0;

            // Strap only matters here; later changes are ignored
            state_d.four_mode  = ~QUAD_SELECT_STRAP_N;
            state_d.clk_phase  = 1'b0;
            state_d.clk_mask   = '0;
            state_d.hold_cnt   = HOLD_NONE;
            state_d.bypass     = ~PLL_ANALOG_SUPPLY;
        end else begin
            state_d.out_en    = 1'b1;
            state_d.copy_b_en = ~CFG.disable_copy_b;

            // Command path: only a cleanly selected cycle moves the outputs
            // A select that lands inside a three-cycle hold is dropped, not
            // queued; the controller must keep the spacing itself
            if (take_cmd) begin
                state_d.cmd_a = CMD_IN;
                state_d.cmd_b = CMD_IN;
                if (CFG.invert_copy_b) begin
                    // Inverted copy B eases routing on the far side
                    // Strobes stay true so both copies decode alike
                    state_d.cmd_b.addr = ~CMD_IN.addr;
                    state_d.cmd_b.bank = ~CMD_IN.bank;
                end
                state_d.hold_cnt = CFG.three_cycle ? HOLD_3T_CYCLES : HOLD_NONE;
            end else if (state_q.hold_cnt != HOLD_NONE) begin
                state_d.hold_cnt = state_q.hold_cnt - 2'h1;
            end
            // Otherwise the command outputs keep their value

            // Control copies follow the inputs every cycle, outside the select
            state_d.ctl_a = CTL_IN;
            state_d.ctl_b = CTL_IN;

            // Rank selects pass every cycle so a deselect is seen too
            // Two-rank mode: the low input pair feeds both the low and the high output pair
            if (state_q.four_mode) begin
                state_d.rank_out_n = RANK_SELECT_IN_N;
            end else begin
                state_d.rank_out_n = {RANK_SELECT_IN_N[1:0], RANK_SELECT_IN_N[1:0]};
            end

            // Capture stage for parity, then check one cycle later
            // The error is not sticky: the next clean cycle releases the pin
            state_d.par_cmd   = CMD_IN;
            state_d.par_bit   = PARITY_IN;
            state_d.par_valid = one_rank;
            state_d.err_oe    = state_q.par_valid && ((^state_q.par_cmd) ^ state_q.par_bit);
            state_d.err_o     = 1'b0;

            // Clock fanout, halved so the outputs stay flip-flops
            // Bypass only reports the test mode; the multiplier is not modelled
            state_d.clk_phase = ~state_q.clk_phase;
            state_d.clk_mask  = ~CFG.disable_clk;
            state_d.bypass    = ~PLL_ANALOG_SUPPLY;
        end

        // Clock pins from the next phase, so each leg is a flip-flop of its own
        // Disabled pairs park low on both legs to save power
        state_d.fan_p = state_d.clk_mask & {CLK_W{state_d.clk_phase}};
        state_d.fan_n = state_d.clk_mask & {CLK_W{~state_d.clk_phase}};
        state_d.fb_n  = ~state_d.clk_phase;
    end

    // No clock enable: every field moves on every edge
    always_ff @(posedge CORE_CLK) begin
        state_q <= state_d;
    end

    // Outputs straight from the state register
    assign CMD_OUT_A             = state_q.cmd_a;
    assign CMD_OUT_B             = state_q.cmd_b;
    assign CTL_OUT_A             = state_q.ctl_a;
    assign CTL_OUT_B             = state_q.ctl_b;
    assign RANK_SELECT_OUT_N     = state_q.rank_out_n;
    assign OUTPUTS_ENABLED       = state_q.out_en;
    assign COPY_B_ENABLED        = state_q.copy_b_en;

    // Open-drain error pin: only its enable ever changes
    assign PARITY_ERROR_OUT_N_O  = state_q.err_o;
    assign PARITY_ERROR_OUT_N_OE = state_q.err_oe;

    // Feedback pair is never masked so the far end can always lock
    assign FEEDBACK_CLK_OUT      = state_q.clk_phase;
    assign FEEDBACK_CLK_OUT_N    = state_q.fb_n;

    // Mode and test status for the board
    assign PLL_BYPASSED          = state_q.bypass;
    assign FOUR_RANK_SELECT_MODE = state_q.four_mode;

    // Each fanout leg straight from its own flop
    for (genvar g = 0; g < CLK_W; g++) begin : g_fan
        assign CLK_FANOUT[g]   = state_q.fan_p[g];
        assign CLK_FANOUT_N[g] = state_q.fan_n[g];
    end

endmodule

`default_nettype wire

// [test/rcd_ctrl_model.sv]
`timescale 1ns/1ps
`default_nettype none
module rcd_ctrl_model
    import rcd_pkg::*;
(
    input  wire cmd_t cmd,
    input  wire logic bad,
    output var  cmd_t cmd_out,
    output var  logic par_out
);
    // Every rank-independent line always driven; bad flips parity on request only
    assign cmd_out = cmd;
    assign par_out = ^cmd ^ bad;
endmodule
`default_nettype wire

// [test/rcd_register_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module rcd_register_sva
    import rcd_pkg::*;
(
    input wire logic              CORE_CLK, NRST, PARITY_IN, OUTPUTS_ENABLED, PARITY_ERROR_OUT_N_OE,
    input wire logic              FOUR_RANK_SELECT_MODE,
    input wire cmd_t              CMD_IN, CMD_OUT_A,
    input wire cfg_t              CFG,
    input wire logic [RANK_W-1:0] RANK_SELECT_IN_N, RANK_SELECT_OUT_N
);
    // One select low in the current mode; the upper pair is ignored with two ranks
    logic one, odd;
    assign one = FOUR_RANK_SELECT_MODE ? $onehot(~RANK_SELECT_IN_N) : $onehot(~RANK_SELECT_IN_N[1:0]);
    assign odd = ^{CMD_IN, PARITY_IN};
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!NRST);
    AST_PAR_BAD: assert property (one && odd |-> ##2 PARITY_ERROR_OUT_N_OE)
        else $error("parity error missed");
    AST_PAR_GOOD: assert property (one && !odd |-> ##2 !PARITY_ERROR_OUT_N_OE)
        else $error("false parity error");
    AST_PAR_SKIP: assert property (!one |-> ##2 !PARITY_ERROR_OUT_N_OE)
        else $error("unchecked cycle flagged");
    AST_CMD_TAKE: assert property (one && !CFG.three_cycle |=> CMD_OUT_A == $past(CMD_IN))
        else $error("command not taken");
    AST_CMD_HOLD: assert property (!one |=> $stable(CMD_OUT_A))
        else $error("command not held");
    AST_CMD_3T: assert property (CFG.three_cycle && $changed(CMD_OUT_A) |=> $stable(CMD_OUT_A) [*2])
        else $error("three-cycle hold broken");
    AST_RANK_TWO: assert property (!FOUR_RANK_SELECT_MODE |=> RANK_SELECT_OUT_N == {2{$past(RANK_SELECT_IN_N[1:0])}})
        else $error("two-rank selects wrong");
    AST_RANK_FOUR: assert property (FOUR_RANK_SELECT_MODE |=> RANK_SELECT_OUT_N == $past(RANK_SELECT_IN_N))
        else $error("four-rank selects wrong");
    // Reset itself must be watched, so this one is never disabled
    AST_RESET: assert property (disable iff (1'b0) !NRST |=> !OUTPUTS_ENABLED && !PARITY_ERROR_OUT_N_OE
        && CMD_OUT_A == CMD_RST && RANK_SELECT_OUT_N == RANK_IDLE_N) else $error("reset state wrong");
endmodule
bind rcd_register rcd_register_sva i_sva (.*);
`default_nettype wire

// [test/test_rcd_register.sv]
`timescale 1ns/1ps
`default_nettype none
module test_rcd_register
    import rcd_pkg::*;
;
    logic       CORE_CLK, NRST, PARITY_IN, QUAD_SELECT_STRAP_N, PLL_ANALOG_SUPPLY, OUTPUTS_ENABLED, COPY_B_ENABLED;
    logic       PARITY_ERROR_OUT_N_O, PARITY_ERROR_OUT_N_OE, FEEDBACK_CLK_OUT, FEEDBACK_CLK_OUT_N, PLL_BYPASSED;
    logic       FOUR_RANK_SELECT_MODE, bad, e1, e2, took;
    logic [3:0] RANK_SELECT_IN_N, RANK_SELECT_OUT_N, CLK_FANOUT, CLK_FANOUT_N;
    cmd_t       CMD_IN, CMD_OUT_A, CMD_OUT_B, cmd, exp_a, exp_b;
    ctl_t       CTL_IN, CTL_OUT_A, CTL_OUT_B;
    cfg_t       CFG;
    int         n_fail = 0, checks_done = 0;
    rcd_register i_dut (
        .CORE_CLK              (CORE_CLK),
        .NRST                  (NRST),
        .CMD_IN                (CMD_IN),
        .PARITY_IN             (PARITY_IN),
        .CTL_IN                (CTL_IN),
        .RANK_SELECT_IN_N      (RANK_SELECT_IN_N),
        .QUAD_SELECT_STRAP_N   (QUAD_SELECT_STRAP_N),
        .PLL_ANALOG_SUPPLY     (PLL_ANALOG_SUPPLY),
        .CFG                   (CFG),
        .CMD_OUT_A             (CMD_OUT_A),
        .CMD_OUT_B             (CMD_OUT_B),
        .CTL_OUT_A             (CTL_OUT_A),
        .CTL_OUT_B             (CTL_OUT_B),
        .RANK_SELECT_OUT_N     (RANK_SELECT_OUT_N),
        .OUTPUTS_ENABLED       (OUTPUTS_ENABLED),
        .COPY_B_ENABLED        (COPY_B_ENABLED),
        .PARITY_ERROR_OUT_N_O  (PARITY_ERROR_OUT_N_O),
        .PARITY_ERROR_OUT_N_OE (PARITY_ERROR_OUT_N_OE),
        .CLK_FANOUT            (CLK_FANOUT),
        .CLK_FANOUT_N          (CLK_FANOUT_N),
        .FEEDBACK_CLK_OUT      (FEEDBACK_CLK_OUT),
        .FEEDBACK_CLK_OUT_N    (FEEDBACK_CLK_OUT_N),
        .PLL_BYPASSED          (PLL_BYPASSED),
        .FOUR_RANK_SELECT_MODE (FOUR_RANK_SELECT_MODE)
    );
    rcd_ctrl_model i_ctrl (.cmd(cmd), .bad(bad), .cmd_out(CMD_IN), .par_out(PARITY_IN));
    initial begin
        CORE_CLK = 1'b0;
        forever #50 CORE_CLK = ~CORE_CLK;
    end
    task automatic chk(string what, logic [31:0] seen, logic [31:0] want);
        checks_done++;
        if (seen !== want) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    function automatic logic one_low(logic [3:0] s, logic four);
        return four ? $onehot(~s) : $onehot(~s[1:0]);
    endfunction
    // Strap is only sampled while reset is low, so it is set here
    task automatic do_reset(logic strap);
        {NRST, QUAD_SELECT_STRAP_N, RANK_SELECT_IN_N, bad} = {1'b0, strap, RANK_IDLE_N, 1'b0};
        repeat (4) @(negedge CORE_CLK);
        chk("outputs_en", OUTPUTS_ENABLED, 0);
        chk("error_oe", PARITY_ERROR_OUT_N_OE, 0);
        chk("fanout", CLK_FANOUT, 0);
        chk("fanout_n", CLK_FANOUT_N, 0);
        chk("fb_n_rst", FEEDBACK_CLK_OUT_N, 1);
        chk("cmd_rst", CMD_OUT_A, CMD_RST);
        chk("rank_rst", RANK_SELECT_OUT_N, RANK_IDLE_N);
        chk("copy_b_rst", COPY_B_ENABLED, 0);
        chk("quad_mode", FOUR_RANK_SELECT_MODE, !strap);
        NRST = 1'b1;
        {exp_a, e1, e2, took} = {CMD_RST, 3'h0};
        $display("reset test done");
    endtask
    // Random traffic; a random nibble on the selects can also give none or several low
    task automatic run(logic four);
        int   hold = 0;
        logic ph   = 1'b0;
        repeat (300) begin
            @(negedge CORE_CLK);
            ph = ~ph;
            chk("cmd_a", CMD_OUT_A, exp_a);
            chk("copy_b_en", COPY_B_ENABLED, !CFG.disable_copy_b);
            chk("ctl_b", CTL_OUT_B, CTL_IN);
            chk("err_o", PARITY_ERROR_OUT_N_O, 0);
            chk("fb", FEEDBACK_CLK_OUT, ph);
            chk("fb_n", FEEDBACK_CLK_OUT_N, !ph);
            chk("fan", CLK_FANOUT, 4'(~CFG.disable_clk & {4{ph}}));
            chk("fan_n", CLK_FANOUT_N, 4'(~CFG.disable_clk & {4{!ph}}));
            if (took) chk("cmd_b", CMD_OUT_B, exp_b);
            chk("rank", RANK_SELECT_OUT_N, four ? RANK_SELECT_IN_N : {2{RANK_SELECT_IN_N[1:0]}});
            chk("ctl", CTL_OUT_A, CTL_IN);
            chk("err_oe", PARITY_ERROR_OUT_N_OE, e2);
            chk("bypass", PLL_BYPASSED, !PLL_ANALOG_SUPPLY);
            RANK_SELECT_IN_N = $urandom_range(0, 3) != 0 ? ~(4'h1 << $urandom_range(0, 3)) : 4'($urandom);
            {cmd, bad, CTL_IN, PLL_ANALOG_SUPPLY} = {22'($urandom), $urandom_range(0, 3) == 0, 4'($urandom), 1'($urandom)};
            {e2, e1} = {e1, one_low(RANK_SELECT_IN_N, four) & bad};
            // A select inside the three-cycle hold is not taken
            if (one_low(RANK_SELECT_IN_N, four) && hold == 0) begin
                {exp_a, exp_b, took} = {cmd, cmd ^ {CFG.invert_copy_b ? 19'h7ffff : 19'h0, 3'h0}, 1'b1};
                hold = CFG.three_cycle ? int'(HOLD_3T_CYCLES) : 0;
            end else if (hold != 0) begin
                hold--;
            end
        end
    endtask
    initial begin
        void'($urandom(32'h86c8ba10));
        {cmd, CTL_IN, CFG, PLL_ANALOG_SUPPLY} = '0;
        do_reset(1'b1);
        run(1'b0);
        $display("two-rank test done");
        CFG.invert_copy_b = 1'b1;
        do_reset(1'b0);
        run(1'b1);
        $display("four-rank test done");
        // Three-cycle timing, copy B off, random clock pairs off
        CFG = {1'b1, 4'($urandom), 1'b1, 1'b0};
        do_reset(1'b1);
        run(1'b0);
        $display("three-cycle test done");
        tally_and_finish();
    end
    // Watchdog far beyond the nine hundred odd cycles the tests need
    initial begin
        #1_000_000;
        n_fail++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
